// file: wdt_pkg.sv
// Shared constants for the watchdog / free-running timer
package wdt_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets (byte offsets on the 16-bit peripheral port)
  localparam logic [4:0] WDT_OFS_MODE_CONTROL = 5'h00;
  localparam logic [4:0] WDT_OFS_CLOCK_DIVIDER = 5'h04;
  localparam logic [4:0] WDT_OFS_PRELOAD = 5'h08;
  localparam logic [4:0] WDT_OFS_COUNTER = 5'h0C;
  localparam logic [4:0] WDT_OFS_STATUS = 5'h10;
  localparam logic [4:0] WDT_OFS_MASK = 5'h14;
  localparam logic [4:0] WDT_OFS_KEY = 5'h18;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int WDT_BIT_WDOG_ENABLE = 0;
  localparam int WDT_BIT_START_COUNTING = 1;
  localparam int WDT_BIT_EXT_CLOCK_SELECT = 2;
  localparam int WDT_BIT_END_COUNT_PENDING = 0;
  localparam int WDT_BIT_END_COUNT_IRQ_MASK = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [15:0] WDT_RST_MODE_CONTROL = 16'h0000;
  localparam logic [7:0] WDT_RST_DIVIDE_FACTOR = 8'hFF;
  localparam logic [15:0] WDT_RST_PRELOAD = 16'hFFFF;
  localparam logic [15:0] WDT_RST_COUNTER = 16'hFFFF;

  ////////////////////////////////////////////////////////////////////////////
  // Key sequence and end-of-count value
  localparam logic [15:0] WDT_KEY_FIRST = 16'hA55A;
  localparam logic [15:0] WDT_KEY_SECOND = 16'h5AA5;
  localparam logic [15:0] WDT_COUNT_END = 16'h0000;

  // Least external clock period, in system clock periods
  localparam int WDT_EXT_MIN_PERIOD_CYC = 4;

  // Key sequence tracker
  typedef enum logic {
    WDT_KEY_IDLE = 1'b0,
    WDT_KEY_ARMED = 1'b1
  } wdt_key_e;

endpackage : wdt_pkg

// file: wdt_edge_sync.sv
`timescale 1ns/100ps
`default_nettype none

// Two-stage synchroniser with rising edge detect on the second stage
module wdt_edge_sync (
  input wire logic clk_i,    // System clock
  input wire logic rst_b_i,  // Synchronous reset, active low
  input wire logic async_i,  // Asynchronous level in
  output logic rise_o        // One-cycle pulse on a rising edge
);

  logic meta;
  logic sync;
  logic sync_d;
  logic next_meta;
  logic next_sync;
  logic next_sync_d;
  logic next_rise;

  // Next values; first stage feeds only the second stage
  always_comb begin
    next_meta = async_i;
    next_sync = meta;
    next_sync_d = sync;
    next_rise = sync & ~sync_d;
  end

  // Register stage
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      meta <= 1'b0;
      sync <= 1'b0;
      sync_d <= 1'b0;
      rise_o <= 1'b0;
    end else begin
      meta <= next_meta;
      sync <= next_sync;
      sync_d <= next_sync_d;
      rise_o <= next_rise;
    end
  end

endmodule : wdt_edge_sync

`default_nettype wire

// file: wdt_timer.sv
// How it works
// - Timer mode until watchdog enable written
// - Start bit loads preload, clear stops counting
// - Zero count flags end, reloads preload
// - Timer keeps reloading until start cleared
// - Restart reloads counter and prescaler both
// - New divide factor applies only on reload
// - Ext select picks ext clock, slow enough
// - Ext select write ignored in watchdog mode
// - Watchdog enable locks; start bit ignored
// - Watchdog entry loads; zero requests reset
// - Key pair A55A then 5AA5 reloads counter
// - Registers accessed only as 16-bit words
// - Reserved bits ignore writes, read zero
// - Counter register reads live count
// - Count clock divided by factor plus one
// - Key ignored off watchdog, reads zero
// - Pending flag: hardware sets, software clears
// - Irq forwarded only while mask set
`timescale 1ns/100ps
`default_nettype none

module wdt_timer (
  input wire logic clk_i,                  // System clock, 40 MHz
  input wire logic rst_b_i,                // Synchronous reset, active low
  input wire logic external_count_clock_i, // Slow external count clock
  input wire logic [4:0] addr_i,           // Register byte offset
  input wire logic wr_i,                   // Word write strobe
  input wire logic rd_i,                   // Word read strobe
  input wire logic [15:0] wdata_i,         // Write data
  output logic [15:0] rdata_o,             // Read data, next cycle
  output logic end_count_irq_o,            // End-of-count irq, level
  output logic system_reset_request_o      // Watchdog reset, sticky
);
  import wdt_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic wdog_enable;
  logic start_counting;
  logic ext_clock_select;
  logic [7:0] divide_factor;
  logic [15:0] preload_value;
  logic [15:0] count;
  logic [7:0] psc_count;
  logic [7:0] psc_active;
  logic end_count_pending;
  logic end_count_irq_mask;
  wdt_key_e key_state;

  logic next_wdog_enable;
  logic next_start_counting;
  logic next_ext_clock_select;
  logic [7:0] next_divide_factor;
  logic [15:0] next_preload_value;
  logic [15:0] next_count;
  logic [7:0] next_psc_count;
  logic [7:0] next_psc_active;
  logic next_end_count_pending;
  logic next_end_count_irq_mask;
  wdt_key_e next_key_state;
  logic [15:0] next_rdata;
  logic next_irq;
  logic next_reset_req;

  logic ext_rise;
  logic wr_ctrl;
  logic wr_key;
  logic reload;
  logic running;
  logic tick;
  logic dec;
  logic end_event;

  ////////////////////////////////////////////////////////////////////////////
  // External clock edge detect
  wdt_edge_sync u_ext_sync (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .async_i(external_count_clock_i),
    .rise_o(ext_rise)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Counting datapath and register writes
  always_comb begin
    wr_ctrl = wr_i && (addr_i == WDT_OFS_MODE_CONTROL);
    wr_key = wr_i && (addr_i == WDT_OFS_KEY) && wdog_enable;

    next_wdog_enable = wdog_enable;
    next_start_counting = start_counting;
    next_ext_clock_select = ext_clock_select;
    next_divide_factor = divide_factor;
    next_preload_value = preload_value;
    next_end_count_irq_mask = end_count_irq_mask;
    next_key_state = key_state;
    reload = 1'b0;

    // Mode control write
    if (wr_ctrl) begin
      if (!wdog_enable) begin
        next_ext_clock_select = wdata_i[WDT_BIT_EXT_CLOCK_SELECT];
        next_start_counting = wdata_i[WDT_BIT_START_COUNTING];
        if (wdata_i[WDT_BIT_WDOG_ENABLE]) begin
          next_wdog_enable = 1'b1;
          next_start_counting = 1'b0;
          reload = 1'b1;
        end else if (wdata_i[WDT_BIT_START_COUNTING] &&
                     !start_counting) begin
          reload = 1'b1;
        end
      end
    end

    // Word-wide register writes, reserved bits dropped
    if (wr_i && addr_i == WDT_OFS_CLOCK_DIVIDER) begin
      next_divide_factor = wdata_i[7:0];
    end
    if (wr_i && addr_i == WDT_OFS_PRELOAD) begin
      next_preload_value = wdata_i;
    end
    if (wr_i && addr_i == WDT_OFS_MASK) begin
      next_end_count_irq_mask = wdata_i[WDT_BIT_END_COUNT_IRQ_MASK];
    end

    // Key sequence; other registers may be accessed between the two writes, any other key value disarms
    if (wr_key) begin
      if (key_state == WDT_KEY_ARMED && wdata_i == WDT_KEY_SECOND) begin
        next_key_state = WDT_KEY_IDLE;
        reload = 1'b1;
      end else if (wdata_i == WDT_KEY_FIRST) begin
        next_key_state = WDT_KEY_ARMED;
      end else begin
        next_key_state = WDT_KEY_IDLE;
      end
    end

    // Prescaler: one decrement per (factor + 1) count clock ticks
    running = wdog_enable || start_counting;
    tick = ext_clock_select ? ext_rise : 1'b1;
    dec = running && tick && (psc_count == 8'h00);
    end_event = dec && (count == WDT_COUNT_END);

    next_count = count;
    next_psc_count = psc_count;
    next_psc_active = psc_active;
    if (reload) begin
      next_count = preload_value;
      next_psc_count = divide_factor;
      next_psc_active = divide_factor;
    end else if (running && tick) begin
      if (psc_count == 8'h00) begin
        next_psc_count = psc_active;
        if (count == WDT_COUNT_END) begin
          next_count = preload_value;
        end else begin
          next_count = count - 16'h0001;
        end
      end else begin
        next_psc_count = psc_count - 8'h01;
      end
    end

    // Pending flag; a new end event wins over a clear
    next_end_count_pending = end_count_pending;
    if (wr_i && addr_i == WDT_OFS_STATUS &&
        !wdata_i[WDT_BIT_END_COUNT_PENDING]) begin
      next_end_count_pending = 1'b0;
    end
    if (end_event && !wdog_enable) begin
      next_end_count_pending = 1'b1;
    end

    next_irq = next_end_count_pending && next_end_count_irq_mask;
    next_reset_req = system_reset_request_o ||
                     (end_event && wdog_enable);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux, unmapped offsets read zero
  always_comb begin
    next_rdata = 16'h0000;
    if (rd_i) begin
      case (addr_i)
        WDT_OFS_MODE_CONTROL: begin
          next_rdata[WDT_BIT_WDOG_ENABLE] = wdog_enable;
          next_rdata[WDT_BIT_START_COUNTING] = start_counting;
          next_rdata[WDT_BIT_EXT_CLOCK_SELECT] = ext_clock_select;
        end
        WDT_OFS_CLOCK_DIVIDER: begin
          next_rdata[7:0] = divide_factor;
        end
        WDT_OFS_PRELOAD: begin
          next_rdata = preload_value;
        end
        WDT_OFS_COUNTER: begin
          next_rdata = count;
        end
        WDT_OFS_STATUS: begin
          next_rdata[WDT_BIT_END_COUNT_PENDING] = end_count_pending;
        end
        WDT_OFS_MASK: begin
          next_rdata[WDT_BIT_END_COUNT_IRQ_MASK] = end_count_irq_mask;
        end
        WDT_OFS_KEY: begin
          next_rdata = 16'h0000;
        end
        default: begin
          next_rdata = 16'h0000;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register stage
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      wdog_enable <= WDT_RST_MODE_CONTROL[WDT_BIT_WDOG_ENABLE];
      start_counting <= WDT_RST_MODE_CONTROL[WDT_BIT_START_COUNTING];
      ext_clock_select <= WDT_RST_MODE_CONTROL[WDT_BIT_EXT_CLOCK_SELECT];
      divide_factor <= WDT_RST_DIVIDE_FACTOR;
      preload_value <= WDT_RST_PRELOAD;
      count <= WDT_RST_COUNTER;
      psc_count <= WDT_RST_DIVIDE_FACTOR;
      psc_active <= WDT_RST_DIVIDE_FACTOR;
      end_count_pending <= 1'b0;
      end_count_irq_mask <= 1'b0;
      key_state <= WDT_KEY_IDLE;
      rdata_o <= 16'h0000;
      end_count_irq_o <= 1'b0;
      system_reset_request_o <= 1'b0;
    end else begin
      wdog_enable <= next_wdog_enable;
      start_counting <= next_start_counting;
      ext_clock_select <= next_ext_clock_select;
      divide_factor <= next_divide_factor;
      preload_value <= next_preload_value;
      count <= next_count;
      psc_count <= next_psc_count;
      psc_active <= next_psc_active;
      end_count_pending <= next_end_count_pending;
      end_count_irq_mask <= next_end_count_irq_mask;
      key_state <= next_key_state;
      rdata_o <= next_rdata;
      end_count_irq_o <= next_irq;
      system_reset_request_o <= next_reset_req;
    end
  end

endmodule : wdt_timer

`default_nettype wire

// file: wdt_timer_assertions.sv
`timescale 1ns/100ps
`default_nettype none
// Port checker for the watchdog timer
module wdt_timer_chk
  import wdt_pkg::*;
(
  input wire logic clk_i, // Clock
  input wire logic rst_b_i, // Reset
  input wire logic external_count_clock_i, // Ext clock
  input wire logic [4:0] addr_i, // Offset
  input wire logic wr_i, // Write
  input wire logic rd_i, // Read
  input wire logic [15:0] wdata_i, // Write data
  input wire logic [15:0] rdata_o, // Read data
  input wire logic end_count_irq_o, // Irq
  input wire logic system_reset_request_o // Reset request
);
  logic mask_seen;
  logic wdog_seen;
  logic next_mask_seen;
  logic next_wdog_seen;
  // Mirror of the mask bit and the watchdog lock
  always_comb begin
    next_mask_seen = mask_seen;
    next_wdog_seen = wdog_seen;
    if (wr_i && addr_i == WDT_OFS_MASK) next_mask_seen = wdata_i[0];
    if (wr_i && addr_i == WDT_OFS_MODE_CONTROL && wdata_i[0])
      next_wdog_seen = 1'b1;
  end
  // Register the mirror
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      mask_seen <= 1'b0;
      wdog_seen <= 1'b0;
    end else begin
      mask_seen <= next_mask_seen;
      wdog_seen <= next_wdog_seen;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  a_rdata_needs_read: assert property (
    rdata_o != 16'h0000 |-> $past(rd_i)) else $error("stray read data");
  a_key_reads_zero: assert property (
    rd_i && addr_i == WDT_OFS_KEY |=> rdata_o == 16'h0000)
    else $error("key read not zero");
  a_div_reserved: assert property (
    rd_i && addr_i == WDT_OFS_CLOCK_DIVIDER |=> rdata_o[15:8] == 8'h00)
    else $error("divider reserved bits set");
  a_flag_reserved: assert property (
    rd_i && (addr_i == WDT_OFS_STATUS || addr_i == WDT_OFS_MASK)
    |=> rdata_o[15:1] == 15'h0000) else $error("flag reserved bits set");
  a_mode_locked: assert property (
    rd_i && addr_i == WDT_OFS_MODE_CONTROL && wdog_seen
    |=> rdata_o[1:0] == 2'b01) else $error("lock not held");
  // Irq is registered from the mask value written in the previous cycle
  a_irq_needs_mask: assert property (
    end_count_irq_o |-> mask_seen) else $error("irq while masked");
  a_reset_sticky: assert property (
    system_reset_request_o |=> system_reset_request_o)
    else $error("reset request dropped");
  a_reset_from_wdog: assert property (
    system_reset_request_o |-> wdog_seen) else $error("reset in timer mode");
  c_irq: cover property ($rose(end_count_irq_o));
  c_reset: cover property ($rose(system_reset_request_o));
  c_key: cover property (wr_i && addr_i == WDT_OFS_KEY && wdog_seen);
endmodule : wdt_timer_chk
bind wdt_timer wdt_timer_chk u_chk (.clk_i(clk_i), .rst_b_i(rst_b_i),
  .external_count_clock_i(external_count_clock_i), .addr_i(addr_i),
  .wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
  .end_count_irq_o(end_count_irq_o),
  .system_reset_request_o(system_reset_request_o));
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// Self-checking bench for the watchdog timer
module tb_top;
  import wdt_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic ext = 1'b0;
  logic ext_run = 1'b0;
  logic [4:0] addr = 5'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata;
  logic irq;
  logic rst_req;
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [15:0] v0, v1, v2, v3;
  // Clocks: system 40 MHz, external eight times slower when running
  always #12.5 clk = ~clk;
  always #100 if (ext_run) ext = ~ext;
  wdt_timer u_dut (.clk_i(clk), .rst_b_i(rst_b),
    .external_count_clock_i(ext), .addr_i(addr), .wr_i(wr), .rd_i(rd),
    .wdata_i(wdata), .rdata_o(rdata), .end_count_irq_o(irq),
    .system_reset_request_o(rst_req));
  // Cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask : chk
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [4:0] a, output logic [15:0] d);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    d = rdata;
  endtask : rd_reg
  // Wait up to n cycles for irq (s=0) or reset request (s=1) to read v
  task automatic wait_sig(input bit s, input logic v, input int n);
    logic g;
    g = s ? rst_req : irq;
    for (int k = 0; k < n && g !== v; k++) begin
      @(negedge clk);
      g = s ? rst_req : irq;
    end
    chk(s ? "reset request" : "irq", {15'h0, v}, {15'h0, g});
  endtask : wait_sig
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_values;
    logic [4:0] a [8] = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h10, 5'h14, 5'h18,
                          5'h1C};
    logic [15:0] e [8] = '{16'h0000, 16'h00FF, 16'hFFFF, 16'hFFFF, 16'h0000,
                           16'h0000, 16'h0000, 16'h0000};
    for (int k = 0; k < 8; k++) begin
      rd_reg(a[k], v0);
      chk("reset value", e[k], v0);
    end
  endtask : t_reset_values
  task automatic t_reserved;
    wr_reg(5'h04, 16'hFFFF);
    rd_reg(5'h04, v0);
    chk("divider", 16'h00FF, v0);
    wr_reg(5'h00, 16'hFFF8);
    rd_reg(5'h00, v0);
    chk("control", 16'h0000, v0);
    wr_reg(5'h0C, 16'h1234);
    rd_reg(5'h0C, v0);
    chk("counter", 16'hFFFF, v0);
    wr_reg(5'h14, 16'hFFFF);
    rd_reg(5'h14, v0);
    chk("mask", 16'h0001, v0);
  endtask : t_reserved
  task automatic t_timer_run;
    wr_reg(5'h04, 16'h0002);
    wr_reg(5'h08, 16'h0100);
    wr_reg(5'h00, 16'h0002);
    rd_reg(5'h0C, v0);
    rd_reg(5'h0C, v1);
    rd_reg(5'h0C, v2);
    rd_reg(5'h0C, v3);
    chk("loaded", 16'h0100, v0);
    chk("divided", 16'h00FE, v3);
    wr_reg(5'h04, 16'h0000);
    rd_reg(5'h0C, v0);
    rd_reg(5'h0C, v1);
    rd_reg(5'h0C, v2);
    rd_reg(5'h0C, v3);
    chk("old divide", 16'h0002, v0 - v3);
    wr_reg(5'h00, 16'h0000);
    rd_reg(5'h0C, v0);
    rd_reg(5'h0C, v1);
    chk("stopped", v0, v1);
    wr_reg(5'h00, 16'h0002);
    rd_reg(5'h0C, v0);
    rd_reg(5'h0C, v1);
    chk("restart", 16'h00FF, v0);
    chk("restart", 16'h00FD, v1);
  endtask : t_timer_run
  task automatic t_end_count;
    wr_reg(5'h08, 16'h0010);
    wr_reg(5'h00, 16'h0000);
    wr_reg(5'h00, 16'h0002);
    wait_sig(1'b0, 1'b1, 40);
    rd_reg(5'h10, v0);
    chk("pending", 16'h0001, v0);
    wr_reg(5'h10, 16'h0000);
    wait_sig(1'b0, 1'b0, 4);
    wait_sig(1'b0, 1'b1, 30);
    wr_reg(5'h14, 16'h0000);
    @(negedge clk);
    chk("masked irq", 16'h0000, {15'h0, irq});
    rd_reg(5'h10, v0);
    chk("pending", 16'h0001, v0);
    wr_reg(5'h00, 16'h0000);
    wr_reg(5'h10, 16'h0000);
  endtask : t_end_count
  task automatic t_ext_clock;
    wr_reg(5'h08, 16'h0100);
    wr_reg(5'h00, 16'h0006);
    rd_reg(5'h0C, v0);
    repeat (10) @(negedge clk);
    rd_reg(5'h0C, v1);
    chk("ext idle", v0, v1);
    ext_run = 1'b1;
    repeat (40) @(negedge clk);
    rd_reg(5'h0C, v2);
    chk("ext count", 16'h0001, {15'h0, v2 < v0});
    ext_run = 1'b0;
    wr_reg(5'h00, 16'h0000);
  endtask : t_ext_clock
  task automatic t_watchdog;
    wr_reg(5'h08, 16'h0030);
    wr_reg(5'h00, 16'h0001);
    rd_reg(5'h00, v0);
    chk("lock", 16'h0001, v0);
    wr_reg(5'h00, 16'h0006);
    rd_reg(5'h00, v0);
    chk("lock", 16'h0001, v0);
    for (int k = 0; k < 3; k++) begin
      repeat (20) @(negedge clk);
      wr_reg(5'h18, 16'hA55A);
      rd_reg(5'h10, v0);
      wr_reg(5'h18, 16'h5AA5);
      chk("no pending", 16'h0000, v0);
    end
    chk("alive", 16'h0000, {15'h0, rst_req});
    wr_reg(5'h18, 16'hA55A);
    wr_reg(5'h18, 16'h1234);
    wr_reg(5'h18, 16'h5AA5);
    rd_reg(5'h0C, v1);
    chk("bad key", 16'h0001, {15'h0, v1 < 16'h002C});
    wait_sig(1'b1, 1'b1, 60);
  endtask : t_watchdog
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test
  // Main sequence
  initial begin
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    t_reset_values();
    t_reserved();
    t_timer_run();
    t_end_count();
    t_ext_clock();
    t_watchdog();
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
